// ==== rtl/handwheel_pkg.sv ====
// Constants and helpers for handwheel jog
package handwheel_pkg;

    // ----------------------------------------------------------------
    // Structure
    // ----------------------------------------------------------------
    localparam int NUM_AXES = 3;
    localparam int NUM_WHEELS = 4;
    localparam int NUM_WRITERS = 3;
    localparam int SYNC_STAGES = 3;
    localparam logic [1:0] GENERAL_WHEEL = 2'h0;
    localparam logic [1:0] WHEEL_OF_X = 2'h1;
    localparam logic [1:0] WHEEL_OF_Z = 2'h3;
    localparam logic [1:0] AXIS_FIRST = 2'h0;
    localparam logic [1:0] AXIS_SECOND_MILL = 2'h1;
    localparam logic [1:0] AXIS_SECOND_LATHE = 2'h2;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PEND_W = 24;
    localparam int POS_W = 16;
    localparam int CNT_W = 16;
    localparam int GEOM_W = 16;
    localparam int LDIR_W = 10;
    localparam int COMP_W = 18;
    localparam int BTN_CNT_W = 28;
    localparam int IDLE_W = 23;
    localparam int TICK_W = 8;

    // ----------------------------------------------------------------
    // Multiplier codes
    // ----------------------------------------------------------------
    localparam logic [1:0] MULT_SEL_X1 = 2'h0;
    localparam logic [1:0] MULT_SEL_X10 = 2'h1;
    localparam logic [1:0] MULT_SEL_X100 = 2'h2;
    localparam logic [PEND_W-1:0] MULT_X1 = 24'h000001;
    localparam logic [PEND_W-1:0] MULT_X10 = 24'h00000A;
    localparam logic [PEND_W-1:0] MULT_X100 = 24'h000064;

    // ----------------------------------------------------------------
    // Geometry selects and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] GEOM_SEL_ANGLE = 2'h0;
    localparam logic [1:0] GEOM_SEL_CENTER1 = 2'h1;
    localparam logic [1:0] GEOM_SEL_CENTER2 = 2'h2;
    localparam logic [GEOM_W-1:0] GEOM_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_INC = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_DEC = 16'hFFFF;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYCLES_PER_MS = 1000000 / CLK_PERIOD_NS;
    localparam int BTN_HOLD_MS = 2000;
    localparam int BTN_HOLD_CYC_DEF = BTN_HOLD_MS * CYCLES_PER_MS;
    localparam int WHEEL_IDLE_MS = 50;
    localparam int WHEEL_IDLE_CYC_DEF = WHEEL_IDLE_MS * CYCLES_PER_MS;
    localparam int STEP_GAP_NS = 1000;
    localparam int STEP_GAP_CYC = (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Angle decode
    // ----------------------------------------------------------------
    localparam int DEG_FULL = 360;
    localparam int DEG_QUAD = 90;
    localparam int DEG_STEP = 15;
    localparam int SIN_STEPS = DEG_QUAD / DEG_STEP;

    // Factor for the selector switch; unused code falls back to x1
    function automatic logic [PEND_W-1:0] multFactor(input logic [1:0] sel);
        case (sel)
            MULT_SEL_X10: multFactor = MULT_X10;
            MULT_SEL_X100: multFactor = MULT_X100;
            default: multFactor = MULT_X1;
        endcase
    endfunction

    // Coarse sine in 15 degree steps, full scale 255
    function automatic logic [7:0] sinStep(input int idx);
        case (idx)
            0: sinStep = 8'h00;
            1: sinStep = 8'h42;
            2: sinStep = 8'h80;
            3: sinStep = 8'hB4;
            4: sinStep = 8'hDD;
            5: sinStep = 8'hF6;
            default: sinStep = 8'hFF;
        endcase
    endfunction

    // Signed {cos, sin} of an angle from the first axis
    function automatic logic [2*LDIR_W-1:0] lineDir(input logic [GEOM_W-1:0] angle);
        int a;
        int quad;
        int idx;
        logic signed [LDIR_W-1:0] c;
        logic signed [LDIR_W-1:0] s;
        a = int'(angle) % DEG_FULL;
        quad = a / DEG_QUAD;
        idx = ((a % DEG_QUAD) + DEG_STEP / 2) / DEG_STEP;
        c = LDIR_W'(sinStep(SIN_STEPS - idx));
        s = LDIR_W'(sinStep(idx));
        case (quad)
            0: lineDir = {c, s};
            1: lineDir = {-s, c};
            2: lineDir = {-c, -s};
            default: lineDir = {s, -c};
        endcase
    endfunction

endpackage

// ==== rtl/quad_step_if.sv ====
// Decoded step events from a wheel decoder
`timescale 1ns/1ps
interface quad_step_if;
    logic step;
    logic up;
    modport source (output step, output up);
    modport sink (input step, input up);
endinterface

// ==== rtl/quad_decoder.sv ====
// Three-stage pin synchroniser and x4 quadrature decoder for one handwheel
`timescale 1ns/1ps
module quad_decoder (
    input wire logic clock,
    input wire logic reset,
    input wire logic phaseA,
    input wire logic phaseB,
    quad_step_if.source stepOut
);
    import handwheel_pkg::*;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] syncA;
        logic [SYNC_STAGES-1:0] syncB;
        logic [1:0] phase;
        logic step;
        logic up;
    } dec_state_t;

    dec_state_t q;
    dec_state_t d;
    logic [1:0] seen;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Level accepted once stages two and three agree
    always_comb begin
        d = q;
        seen = q.phase;
        d.syncA = {q.syncA[SYNC_STAGES-2:0], phaseA};
        d.syncB = {q.syncB[SYNC_STAGES-2:0], phaseB};
        if (q.syncA[1] == q.syncA[2]) begin
            seen[1] = q.syncA[2];
        end
        if (q.syncB[1] == q.syncB[2]) begin
            seen[0] = q.syncB[2];
        end
        d.phase = seen;
        // Single-channel edge is one count; a double jump is dropped
        d.step = ^(seen ^ q.phase);
        d.up = q.phase[1] ^ seen[0];
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign stepOut.step = q.step;
    assign stepOut.up = q.up;

endmodule

// ==== rtl/handwheel_jog_control.sv ====
// Handwheel jog control: routing, axis select, path mode, pulse counts
//
// Notes on behaviour
// - Each wheel edge counts once (x4), then scaled by 1, 10 or 100.
// - Three individual wheels, each moving only its bound axis.
// - General wheel moves only the selected axis, sign following rotation.
// - Individual wheel stop drops distance still owed to its axis.
// - General wheel stop drops owed distance only if stop select set.
// - Short button press picks first axis, then next, wrapping round.
// - Button held over two seconds deselects the axis.
// - A jog key selects its axis for the general wheel.
// - While an individual wheel moves, general counts are ignored.
// - Path mode enable input: 0 off, 1 on.
// - Path type input: 0 straight line, 1 circular arc.
// - Line uses angle from first axis; arc uses two centres.
// - Angle and centres read and written by three sources.
// - In path mode one wheel drives both plane axes along the path.
// - Path wheel is general wheel, else X wheel (mill) or Z wheel (lathe).
// - General wheel on path: individual wheels keep their axes.
// - Readable accumulated pulse count for each of four wheels.
`timescale 1ns/1ps
module handwheel_jog_control #(
    parameter int BTN_HOLD_CYCLES = handwheel_pkg::BTN_HOLD_CYC_DEF,
    parameter int WHEEL_IDLE_CYCLES = handwheel_pkg::WHEEL_IDLE_CYC_DEF
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [handwheel_pkg::NUM_WHEELS-1:0] wheelPhaseA,
    input wire logic [handwheel_pkg::NUM_WHEELS-1:0] wheelPhaseB,
    input wire logic handwheelMode,
    input wire logic [1:0] jogMultSel,
    input wire logic axisSelButton,
    input wire logic [handwheel_pkg::NUM_AXES-1:0] jogKeySelect,
    input wire logic generalPresent,
    input wire logic latheModel,
    input wire logic overflowStopSelect,
    input wire logic pathModeEnable,
    input wire logic pathTypeSelect,
    input wire logic [handwheel_pkg::NUM_WRITERS-1:0] geomWrEn,
    input wire logic [handwheel_pkg::NUM_WRITERS-1:0][1:0] geomWrSel,
    input wire logic [handwheel_pkg::NUM_WRITERS-1:0][handwheel_pkg::GEOM_W-1:0] geomWrData,
    output logic [handwheel_pkg::NUM_AXES-1:0] axisStep,
    output logic [handwheel_pkg::NUM_AXES-1:0] axisDir,
    output logic selValid,
    output logic [1:0] selAxis,
    output logic [handwheel_pkg::CNT_W-1:0] wheel1PulseCount,
    output logic [handwheel_pkg::CNT_W-1:0] wheel2PulseCount,
    output logic [handwheel_pkg::CNT_W-1:0] wheel3PulseCount,
    output logic [handwheel_pkg::CNT_W-1:0] wheel4PulseCount,
    output logic [handwheel_pkg::GEOM_W-1:0] pathLineAngle,
    output logic [handwheel_pkg::GEOM_W-1:0] arcCenterFirstAxis,
    output logic [handwheel_pkg::GEOM_W-1:0] arcCenterSecondAxis
);
    import handwheel_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_STAGES-1:0] btnSync;
        logic btnLevel;
        logic btnLong;
        logic [BTN_CNT_W-1:0] btnCnt;
        logic selValid;
        logic [1:0] selAxis;
        logic [NUM_WHEELS-1:0][IDLE_W-1:0] idleCnt;
        logic [NUM_WHEELS-1:0][CNT_W-1:0] pulseCnt;
        logic [NUM_AXES-1:0][PEND_W-1:0] pend;
        logic [PEND_W-1:0] pathPend;
        logic [NUM_AXES-1:0][POS_W-1:0] pos;
        logic [COMP_W:0] err;
        logic [TICK_W-1:0] tickCnt;
        logic [GEOM_W-1:0] geomAngle;
        logic [GEOM_W-1:0] geomCenter1;
        logic [GEOM_W-1:0] geomCenter2;
        logic [NUM_AXES-1:0] axisStep;
        logic [NUM_AXES-1:0] axisDir;
    } jog_state_t;

    // Idle counters start saturated: no wheel busy after reset
    localparam jog_state_t RESET_STATE = '{idleCnt: '1, default: '0};
    localparam logic [IDLE_W-1:0] IDLE_DONE = IDLE_W'(WHEEL_IDLE_CYCLES);
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(WHEEL_IDLE_CYCLES - 1);
    localparam logic [BTN_CNT_W-1:0] HOLD_LAST = BTN_CNT_W'(BTN_HOLD_CYCLES - 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_GAP_CYC - 1);

    jog_state_t q;
    jog_state_t d;

    logic [NUM_WHEELS-1:0] wStep;
    logic [NUM_WHEELS-1:0] wUp;

    // ----------------------------------------------------------------
    // Wheel decoders
    // ----------------------------------------------------------------
    quad_step_if wheelIf[NUM_WHEELS] ();

    genvar g;
    generate
        for (g = 0; g < NUM_WHEELS; g++) begin : gWheel
            quad_decoder decoder (
                .clock(clock),
                .reset(reset),
                .phaseA(wheelPhaseA[g]),
                .phaseB(wheelPhaseB[g]),
                .stepOut(wheelIf[g].source)
            );
            assign wStep[g] = wheelIf[g].step;
            assign wUp[g] = wheelIf[g].up;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [PEND_W-1:0] amt;
        logic [PEND_W-1:0] delta;
        logic [NUM_WHEELS-1:0] stopNow;
        logic indivActive;
        logic pathOn;
        logic [1:0] pathWheel;
        logic [1:0] secondAxis;
        logic tick;
        logic [2*LDIR_W-1:0] ld;
        logic signed [COMP_W-1:0] cx;
        logic signed [COMP_W-1:0] cy;
        logic signed [COMP_W-1:0] mx;
        logic signed [COMP_W-1:0] my;
        logic signed [COMP_W:0] errNext;
        logic [NUM_AXES-1:0] claim;
        logic [NUM_AXES-1:0] claimDir;
        logic stepNow;
        logic dirNow;
        amt = multFactor(jogMultSel);
        delta = '0;
        stopNow = '0;
        indivActive = 1'b0;
        pathOn = pathModeEnable;
        pathWheel = generalPresent ? GENERAL_WHEEL : (latheModel ? WHEEL_OF_Z : WHEEL_OF_X);
        secondAxis = latheModel ? AXIS_SECOND_LATHE : AXIS_SECOND_MILL;
        tick = (q.tickCnt == TICK_LAST);
        ld = '0;
        cx = '0;
        cy = '0;
        mx = '0;
        my = '0;
        errNext = '0;
        claim = '0;
        claimDir = '0;
        stepNow = 1'b0;
        dirNow = 1'b0;
        d = q;
        d.axisStep = '0;

        // Button: synchronise, accept when stages agree
        d.btnSync = {q.btnSync[SYNC_STAGES-2:0], axisSelButton};
        if (q.btnSync[1] == q.btnSync[2]) begin
            d.btnLevel = q.btnSync[2];
        end
        if (q.btnLevel) begin
            if (q.btnCnt == HOLD_LAST && !q.btnLong) begin
                d.btnLong = 1'b1;
                d.selValid = 1'b0;
            end else if (!q.btnLong) begin
                d.btnCnt = q.btnCnt + BTN_CNT_W'(1);
            end
        end
        // Short press acts on release, so a long hold never also advances
        if (q.btnLevel && !d.btnLevel) begin
            if (!q.btnLong) begin
                if (!q.selValid) begin
                    d.selValid = 1'b1;
                    d.selAxis = AXIS_FIRST;
                end else if (q.selAxis == 2'(NUM_AXES - 1)) begin
                    d.selAxis = AXIS_FIRST;
                end else begin
                    d.selAxis = q.selAxis + 2'(1);
                end
            end
            d.btnCnt = '0;
            d.btnLong = 1'b0;
        end

        // Jog keys pick the general axis, lowest first
        for (int a = NUM_AXES - 1; a >= 0; a--) begin
            if (jogKeySelect[a]) begin
                d.selValid = 1'b1;
                d.selAxis = 2'(a);
            end
        end

        // Pulse counters and per-wheel idle timers
        for (int i = 0; i < NUM_WHEELS; i++) begin
            if (wStep[i]) begin
                d.pulseCnt[i] = q.pulseCnt[i] + (wUp[i] ? CNT_INC : CNT_DEC);
                d.idleCnt[i] = '0;
            end else if (q.idleCnt[i] < IDLE_DONE) begin
                d.idleCnt[i] = q.idleCnt[i] + IDLE_W'(1);
                stopNow[i] = (q.idleCnt[i] == IDLE_LAST);
            end
        end
        for (int i = 1; i < NUM_WHEELS; i++) begin
            indivActive = indivActive | (q.idleCnt[i] < IDLE_DONE);
        end

        // Individual wheels feed own axis or the path
        for (int i = 1; i < NUM_WHEELS; i++) begin
            delta = wUp[i] ? amt : PEND_W'(0) - amt;
            if (handwheelMode && wStep[i]) begin
                if (pathOn && pathWheel == 2'(i)) begin
                    d.pathPend = d.pathPend + delta;
                end else begin
                    d.pend[i-1] = d.pend[i-1] + delta;
                end
            end
        end

        // General wheel locked out while an individual is busy
        delta = wUp[GENERAL_WHEEL] ? amt : PEND_W'(0) - amt;
        if (handwheelMode && wStep[GENERAL_WHEEL] && !indivActive) begin
            if (pathOn && generalPresent) begin
                d.pathPend = d.pathPend + delta;
            end else if (q.selValid) begin
                d.pend[q.selAxis] = d.pend[q.selAxis] + delta;
            end
        end

        // Wheel stopped with distance owed
        for (int i = 1; i < NUM_WHEELS; i++) begin
            if (stopNow[i]) begin
                d.pend[i-1] = '0;
                if (pathWheel == 2'(i)) begin
                    d.pathPend = '0;
                end
            end
        end
        if (stopNow[GENERAL_WHEEL] && overflowStopSelect) begin
            if (q.selValid) begin
                d.pend[q.selAxis] = '0;
            end
            if (generalPresent) begin
                d.pathPend = '0;
            end
        end

        // Pacing caps every axis at the top rate
        d.tickCnt = tick ? '0 : q.tickCnt + TICK_W'(1);

        // Path direction: line, or tangent about the centre
        if (tick && d.pathPend != '0) begin
            if (!pathTypeSelect) begin
                ld = lineDir(q.geomAngle);
                cx = COMP_W'($signed(ld[2*LDIR_W-1:LDIR_W]));
                cy = COMP_W'($signed(ld[LDIR_W-1:0]));
            end else begin
                cx = COMP_W'($signed(q.geomCenter2)) - COMP_W'($signed(q.pos[secondAxis]));
                cy = COMP_W'($signed(q.pos[AXIS_FIRST])) - COMP_W'($signed(q.geomCenter1));
            end
            if ($signed(d.pathPend) < 0) begin
                cx = -cx;
                cy = -cy;
            end
            mx = (cx < 0) ? -cx : cx;
            my = (cy < 0) ? -cy : cy;
            // Bresenham split: major axis every step, minor on error wrap
            if (mx >= my && mx != '0) begin
                claim[AXIS_FIRST] = 1'b1;
                claimDir[AXIS_FIRST] = (cx >= 0);
                errNext = $signed(q.err) + (COMP_W + 1)'(my);
                if (errNext >= (COMP_W + 1)'(mx)) begin
                    errNext = errNext - (COMP_W + 1)'(mx);
                    claim[secondAxis] = 1'b1;
                    claimDir[secondAxis] = (cy >= 0);
                end
            end else if (my != '0) begin
                claim[secondAxis] = 1'b1;
                claimDir[secondAxis] = (cy >= 0);
                errNext = $signed(q.err) + (COMP_W + 1)'(mx);
                if (errNext >= (COMP_W + 1)'(my)) begin
                    errNext = errNext - (COMP_W + 1)'(my);
                    claim[AXIS_FIRST] = 1'b1;
                    claimDir[AXIS_FIRST] = (cx >= 0);
                end
            end
            d.err = errNext;
            d.pathPend = ($signed(d.pathPend) < 0) ? d.pathPend + PEND_W'(1)
                                                   : d.pathPend - PEND_W'(1);
        end

        // Steps; path claims win, own distance waits
        for (int a = 0; a < NUM_AXES; a++) begin
            stepNow = 1'b0;
            dirNow = q.axisDir[a];
            if (tick && claim[a]) begin
                stepNow = 1'b1;
                dirNow = claimDir[a];
            end else if (tick && d.pend[a] != '0) begin
                stepNow = 1'b1;
                dirNow = ($signed(d.pend[a]) > 0);
                d.pend[a] = dirNow ? d.pend[a] - PEND_W'(1) : d.pend[a] + PEND_W'(1);
            end
            d.axisStep[a] = stepNow;
            d.axisDir[a] = dirNow;
            if (stepNow) begin
                d.pos[a] = dirNow ? q.pos[a] + POS_W'(1) : q.pos[a] - POS_W'(1);
            end
        end

        // Geometry writes; lowest source wins a clash
        for (int s = NUM_WRITERS - 1; s >= 0; s--) begin
            if (geomWrEn[s]) begin
                case (geomWrSel[s])
                    GEOM_SEL_ANGLE: begin
                        d.geomAngle = geomWrData[s];
                    end
                    GEOM_SEL_CENTER1: begin
                        d.geomCenter1 = geomWrData[s];
                    end
                    GEOM_SEL_CENTER2: begin
                        d.geomCenter2 = geomWrData[s];
                    end
                    default: begin
                        d.geomAngle = d.geomAngle;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, straight from the state register
    // ----------------------------------------------------------------
    assign axisStep = q.axisStep;
    assign axisDir = q.axisDir;
    assign selValid = q.selValid;
    assign selAxis = q.selAxis;
    // Raw x4 counts, not scaled; supervisor takes differences
    assign wheel1PulseCount = q.pulseCnt[0];
    assign wheel2PulseCount = q.pulseCnt[1];
    assign wheel3PulseCount = q.pulseCnt[2];
    assign wheel4PulseCount = q.pulseCnt[3];
    assign pathLineAngle = q.geomAngle;
    assign arcCenterFirstAxis = q.geomCenter1;
    assign arcCenterSecondAxis = q.geomCenter2;

endmodule

// ==== test/handwheel_jog_control_assertions.sv ====
// Port checker for handwheel jog control
`timescale 1ns/1ps
module handwheel_jog_control_assertions (
    input wire logic clock,
    input wire logic reset,
    input wire logic [2:0] geomWrEn,
    input wire logic [2:0][1:0] geomWrSel,
    input wire logic [2:0][15:0] geomWrData,
    input wire logic [2:0] axisStep,
    input wire logic selValid,
    input wire logic [1:0] selAxis,
    input wire logic [15:0] wheel1PulseCount,
    input wire logic [15:0] pathLineAngle
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Source 0 wins; data lands next edge
    property p_angle;
        geomWrEn[0] && geomWrSel[0] == 2'h0 |=> pathLineAngle == $past(geomWrData[0]); endproperty
    a_angle: assert property (p_angle) else $error("angle write lost");
    property p_hold; geomWrEn == 3'h0 |=> $stable(pathLineAngle); endproperty
    a_hold: assert property (p_hold) else $error("angle moved");
    // Steps are paced
    property p_pace0; axisStep[0] |=> !axisStep[0] [*8]; endproperty
    a_pace0: assert property (p_pace0) else $error("axis 0 step pace");
    property p_pace1; axisStep[1] |=> !axisStep[1] [*8]; endproperty
    a_pace1: assert property (p_pace1) else $error("axis 1 step pace");
    property p_pace2; axisStep[2] |=> !axisStep[2] [*8]; endproperty
    a_pace2: assert property (p_pace2) else $error("axis 2 step pace");
    // One edge moves the count by one
    property p_count; $changed(wheel1PulseCount) |->
        wheel1PulseCount - $past(wheel1PulseCount) inside {16'h0001, 16'hFFFF}; endproperty
    a_count: assert property (p_count) else $error("count jumped");
    property p_sel; selValid |-> selAxis != 2'h3; endproperty
    a_sel: assert property (p_sel) else $error("no such axis");
    property p_idle; !selValid |-> selAxis == 2'h0 || $stable(selAxis); endproperty
    a_idle: assert property (p_idle) else $error("selection drift");
endmodule
bind handwheel_jog_control handwheel_jog_control_assertions chk (.clock, .reset, .geomWrEn,
    .geomWrSel, .geomWrData, .axisStep, .selValid, .selAxis, .wheel1PulseCount, .pathLineAngle);

// ==== test/wheel_model.sv ====
// Quadrature handwheels: one gray-coded phase pair per wheel
`timescale 1ns/1ps
module wheel_model (
    input wire logic clock,
    input wire logic [3:0] turnUp,
    input wire logic [3:0] turnDn,
    output logic [3:0] phaseA,
    output logic [3:0] phaseB
);
    logic [3:0][1:0] pos_q = '0;
    // Up walks {A,B} 00,01,11,10, one channel per edge
    always_ff @(posedge clock) begin
        for (int w = 0; w < 4; w++) begin
            pos_q[w] <= pos_q[w] + 2'(turnUp[w]) - 2'(turnDn[w]);
        end
    end
    always_comb begin
        for (int w = 0; w < 4; w++) begin
            {phaseA[w], phaseB[w]} = pos_q[w] ^ (pos_q[w] >> 1);
        end
    end
endmodule

// ==== test/handwheel_jog_control_tb.sv ====
// Self-checking bench for handwheel jog control
`timescale 1ns/1ps
module handwheel_jog_control_tb;
    logic clock = 1'b0, reset = 1'b1, handwheelMode = 1'b0, axisSelButton = 1'b0, selValid;
    logic pathModeEnable = 1'b0, overflowStopSelect = 1'b1;
    logic [1:0] jogMultSel = 2'h0, selAxis;
    logic [2:0] jogKeySelect = 3'h0, geomWrEn = 3'h0, axisStep, axisDir;
    logic [2:0][1:0] geomWrSel = '0;
    logic [2:0][15:0] geomWrData = '0;
    logic [3:0] pA, pB, turnUp = 4'h0, turnDn = 4'h0;
    logic [15:0] cnt [4], geom [3], expGeom [3] = '{default: '0};
    int expCnt [4] = '{0, 0, 0, 0}, stepCnt [3] = '{0, 0, 0};
    int errors = 0, n_compared = 0, cycles = 0;
    logic [31:0] seed = 32'hCA45;
    // Short times keep the run brief
    handwheel_jog_control #(.BTN_HOLD_CYCLES(50), .WHEEL_IDLE_CYCLES(300)) dut (
        .clock, .reset, .wheelPhaseA(pA), .wheelPhaseB(pB),
        .handwheelMode, .jogMultSel, .axisSelButton,
        .jogKeySelect, .generalPresent(1'b1), .latheModel(1'b0),
        .overflowStopSelect, .pathModeEnable, .pathTypeSelect(1'b0),
        .geomWrEn, .geomWrSel, .geomWrData,
        .axisStep, .axisDir, .selValid, .selAxis,
        .wheel1PulseCount(cnt[0]), .wheel2PulseCount(cnt[1]), .wheel3PulseCount(cnt[2]),
        .wheel4PulseCount(cnt[3]), .pathLineAngle(geom[0]), .arcCenterFirstAxis(geom[1]),
        .arcCenterSecondAxis(geom[2]));
    wheel_model wheels (.clock(clock), .turnUp(turnUp), .turnDn(turnDn), .phaseA(pA), .phaseB(pB));
    initial forever #5 clock = ~clock;
    // Step tally and hang guard
    always @(posedge clock) begin
        cycles++;
        for (int i = 0; i < 3; i++) stepCnt[i] += int'(axisStep[i]);
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chkVal(logic [15:0] got, logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkSteps(int axis, int lo, int hi);
        n_compared++;
        if (stepCnt[axis] < lo || stepCnt[axis] > hi) begin
            errors++;
            $display("ERROR %0t: axis %0d made %0d steps", $time, axis, stepCnt[axis]);
        end
    endtask
    // Edges 22 cycles apart, inside the idle window
    task automatic turn(int w, bit up, int n);
        repeat (n) begin
            {turnUp[w], turnDn[w]} = {up, !up};
            @(negedge clock);
            {turnUp[w], turnDn[w]} = 2'b00;
            expCnt[w] += up ? 1 : -1;
            repeat (21) @(negedge clock);
        end
    endtask
    task automatic press(int n);
        axisSelButton = 1'b1;
        repeat (n) @(negedge clock);
        axisSelButton = 1'b0;
        repeat (12) @(negedge clock);
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clock);
        reset = 1'b0;
        // Each source and select; select 3 is ignored
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 4; k++) begin
                geomWrSel[s] = 2'(k);
                geomWrData[s] = 16'(rnd());
                geomWrEn = 3'(1 << s);
                if (k < 3) expGeom[k] = geomWrData[s];
                @(negedge clock);
                geomWrEn = 3'h0;
                @(negedge clock);
                for (int g = 0; g < 3; g++) chkVal(geom[g], expGeom[g]);
            end
        end
        $display("geometry done");
        for (int w = 0; w < 4; w++) turn(w, rnd() % 2, 1 + int'(rnd() % 4));
        for (int w = 0; w < 4; w++) chkVal(cnt[w], 16'(expCnt[w]));
        repeat (400) @(negedge clock);
        handwheelMode = 1'b1;
        stepCnt = '{0, 0, 0};
        turn(1, 1'b1, 3);
        repeat (400) @(negedge clock);
        chkSteps(0, 3, 3);
        chkSteps(1, 0, 0);
        chkVal(16'(axisDir), 16'h0001);
        // x10 and x100 edges cut short once the wheel stops
        for (int m = 1; m < 3; m++) begin
            jogMultSel = 2'(m);
            stepCnt = '{0, 0, 0};
            turn(2, 1'b0, 1);
            repeat (500) @(negedge clock);
            chkSteps(1, 1, 4);
        end
        $display("wheel tests done");
        for (int i = 0; i < 4; i++) begin
            press(5);
            chkVal(16'({selValid, selAxis}), 16'(4 + i % 3));
        end
        press(80);
        chkVal(16'(selValid), 16'h0000);
        jogKeySelect = 3'h4;
        @(negedge clock);
        jogKeySelect = 3'h0;
        repeat (5) @(negedge clock);
        chkVal(16'({selValid, selAxis}), 16'h0006);
        jogMultSel = 2'h0;
        stepCnt = '{0, 0, 0};
        turn(0, 1'b0, 2);
        repeat (400) @(negedge clock);
        chkSteps(2, 2, 2);
        chkSteps(0, 0, 0);
        chkVal(16'(axisDir[2]), 16'h0000);
        stepCnt = '{0, 0, 0};
        turn(3, 1'b1, 1);
        turn(0, 1'b1, 1);
        repeat (400) @(negedge clock);
        chkSteps(2, 1, 1);
        $display("selection tests done");
        close_out();
    end
endmodule
